// [pkg/sbc_regs.svh]
// synthesizer buffer and calibration register block: offsets, fields, resets, counts
// assumes: included by bare name; holds definitions only
`ifndef SBC_REGS_SVH
`define SBC_REGS_SVH

// ****************************************
// register indices, byte address = index * 4
// ****************************************
`define SBC_IDX_SWING      6'h18
`define SBC_IDX_CURRENT    6'h19
`define SBC_IDX_BW         6'h1A
`define SBC_IDX_CAL        6'h1B
`define SBC_IDX_CTRL       6'h30
`define SBC_IDX_RESULT     6'h31
`define SBC_IDX_STATE      6'h32
`define SBC_IDX_IRQ_STAT   6'h33
`define SBC_IDX_IRQ_MASK   6'h34

// ****************************************
// field positions
// ****************************************
`define SBC_F_PRE          7:6
`define SBC_F_TX           2:0
`define SBC_F_BW           7:0
`define SBC_F_CAL_START    7
`define SBC_F_CAL_DUAL     6
`define SBC_F_CAL_WAIT     5:4
`define SBC_F_CAL_SELECT   3
`define SBC_F_CAL_ITER     2:0
`define SBC_F_FREQ_SEL     0
`define SBC_F_LOCK_SEL     7:4
`define SBC_F_RES_A        3:0
`define SBC_F_RES_B        7:4
`define SBC_F_BUSY         0
`define SBC_F_COMPLETE     1
`define SBC_F_EV_DONE      0
`define SBC_F_EV_REFUSED   1

// ****************************************
// reset values
// ****************************************
`define SBC_RST_PRE_SWING  2'h3
`define SBC_RST_TX_SWING   3'h1
`define SBC_RST_PRE_CUR    2'h1
`define SBC_RST_TX_CUR     3'h5
`define SBC_RST_BW         8'h86
`define SBC_RST_CAL_WAIT   2'h0
`define SBC_RST_CAL_SELECT 1'h1
`define SBC_RST_CAL_ITER   3'h5
`define SBC_RST_DAC        4'h0

// ****************************************
// lock pin codes, dividers and counts
// ****************************************
`define SBC_LOCK_HIGH      4'h1
`define SBC_LOCK_CAL_DONE  4'h5
`define SBC_DIV_NEW0       9'h008
`define SBC_DIV_NEW1       9'h010
`define SBC_DIV_NEW2       9'h028
`define SBC_DIV_NEW3       9'h050
`define SBC_DIV_OLD01      9'h050
`define SBC_DIV_OLD2       9'h0A0
`define SBC_DIV_OLD3       9'h100
`define SBC_DAC_LAST       4'h8
// legacy run lengths in reference periods; the reference is pclk here
`define SBC_LEGACY_CYC0    90000
`define SBC_LEGACY_CYC1    110000
`define SBC_LEGACY_CYC2    130000
`define SBC_LEGACY_CYC3    200000

`endif

// [pkg/sbc_pkg.sv]
// synthesizer buffer and calibration register block: shared types
// assumes: nothing beyond a SystemVerilog compiler
package sbc_pkg;

    typedef enum logic [0:0] {
        SBC_CAL_IDLE,
        SBC_CAL_RUN
    } sbc_cal_state_t;

endpackage

// [pkg/sbc_cal_if.sv]
// carrier between the register block and its calibration engine
// assumes: both ends run on the same pclk
`timescale 1ns/100ps
`default_nettype none
interface sbc_cal_if;
    logic       start;
    logic       legacy;
    logic [1:0] wait_code;
    logic [2:0] dac_start;
    logic       busy;
    logic       done;
    logic [3:0] dac;

    modport ctl (output start, legacy, wait_code, dac_start, input busy, done, dac);
    modport eng (input start, legacy, wait_code, dac_start, output busy, done, dac);
endinterface
`default_nettype wire

// [design/sbc_cal_engine.sv]
// calibration sequencer: divided calibration clock and dac iteration
// assumes: start is a one-cycle pulse from the register block, same clock
`timescale 1ns/100ps
`default_nettype none
`include "sbc_regs.svh"
module sbc_cal_engine #(
    parameter int unsigned LEGACY_CYC0 = `SBC_LEGACY_CYC0,
    parameter int unsigned LEGACY_CYC1 = `SBC_LEGACY_CYC1,
    parameter int unsigned LEGACY_CYC2 = `SBC_LEGACY_CYC2,
    parameter int unsigned LEGACY_CYC3 = `SBC_LEGACY_CYC3
) (
    input  wire logic pclk,
    input  wire logic presetn,
    sbc_cal_if.eng    cal
);
    sbc_pkg::sbc_cal_state_t state, next_state;
    logic [8:0]  div_len, next_div_len;
    logic [8:0]  div_cnt, next_div_cnt;
    logic [17:0] run_len, next_run_len;
    logic [17:0] run_cnt, next_run_cnt;
    logic        legacy, next_legacy;
    logic [3:0]  dac, next_dac;
    logic        done, next_done;
    logic        tick;

    // ****************************************
    // divider and run length selection
    // ****************************************
    function automatic logic [8:0] divider(input logic old, input logic [1:0] code);
        if (!old) begin
            case (code)
                2'h0:    divider = `SBC_DIV_NEW0;
                2'h1:    divider = `SBC_DIV_NEW1;
                2'h2:    divider = `SBC_DIV_NEW2;
                default: divider = `SBC_DIV_NEW3;
            endcase
        end else begin
            case (code)
                2'h2:    divider = `SBC_DIV_OLD2;
                2'h3:    divider = `SBC_DIV_OLD3;
                default: divider = `SBC_DIV_OLD01;
            endcase
        end
    endfunction

    // stored as length minus one so the end test is a plain compare
    function automatic logic [17:0] legacy_last(input logic [1:0] code);
        case (code)
            2'h0:    legacy_last = 18'(LEGACY_CYC0 - 1);
            2'h1:    legacy_last = 18'(LEGACY_CYC1 - 1);
            2'h2:    legacy_last = 18'(LEGACY_CYC2 - 1);
            default: legacy_last = 18'(LEGACY_CYC3 - 1);
        endcase
    endfunction

    // ****************************************
    // sequencer
    // ****************************************
    assign tick = (div_cnt == div_len - 9'h001);

    always_comb begin
        next_state   = state;
        next_div_len = div_len;
        next_div_cnt = div_cnt;
        next_run_len = run_len;
        next_run_cnt = run_cnt;
        next_legacy  = legacy;
        next_dac     = dac;
        next_done    = 1'b0;
        case (state)
            sbc_pkg::SBC_CAL_IDLE: begin
                if (cal.start) begin
                    next_state   = sbc_pkg::SBC_CAL_RUN;
                    next_legacy  = cal.legacy;
                    next_div_len = divider(cal.legacy, cal.wait_code); // (RL8) (RL9)
                    next_run_len = legacy_last(cal.wait_code); // (RL10)
                    next_div_cnt = 9'h000;
                    next_run_cnt = 18'h00000;
                    next_dac     = {1'b0, cal.dac_start} + 4'h1; // (RL12)
                end
            end
            sbc_pkg::SBC_CAL_RUN: begin
                next_run_cnt = run_cnt + 18'h00001;
                if (tick) begin
                    next_div_cnt = 9'h000;
                    if (dac != `SBC_DAC_LAST) begin
                        next_dac = dac + 4'h1;
                    end
                end else begin
                    next_div_cnt = div_cnt + 9'h001;
                end
                // legacy runs a fixed time, the new routine ends at the last dac step
                if (legacy ? (run_cnt == run_len) : (tick && dac == `SBC_DAC_LAST)) begin // (RL10)
                    next_done  = 1'b1;
                    next_state = sbc_pkg::SBC_CAL_IDLE;
                end
            end
            default: next_state = sbc_pkg::SBC_CAL_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state   <= sbc_pkg::SBC_CAL_IDLE;
            div_len <= `SBC_DIV_NEW0;
            div_cnt <= 9'h000;
            run_len <= 18'h00000;
            run_cnt <= 18'h00000;
            legacy  <= 1'b0;
            dac     <= `SBC_RST_DAC;
            done    <= 1'b0;
        end else begin
            state   <= next_state;
            div_len <= next_div_len;
            div_cnt <= next_div_cnt;
            run_len <= next_run_len;
            run_cnt <= next_run_cnt;
            legacy  <= next_legacy;
            dac     <= next_dac;
            done    <= next_done;
        end
    end

    assign cal.busy = (state == sbc_pkg::SBC_CAL_RUN);
    assign cal.done = done;
    assign cal.dac  = dac;
endmodule
`default_nettype wire

// [design/sbc_regs.sv]
// synthesizer buffer and calibration registers behind an APB slave
// assumes: zero-wait APB master on pclk; reference clock taken as pclk
//
// Decided for this implementation: register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "sbc_regs.svh"
// Behaviour
// (RL1) prescaler swing, bits 7:6, reset 3
// (RL2) LO buffer swing, bits 2:0, reset 1
// (RL3) prescaler current, bits 7:6, reset 1
// (RL4) LO buffer current, bits 2:0, reset 5
// (RL5) charge pump scaling byte, reset 134
// (RL6) start bit rising edge starts calibration
// (RL7) dual bit stores result in both slots
// (RL8) new routine dividers 8, 16, 40, 80
// (RL9) legacy routine dividers 80, 80, 160, 256
// (RL10) legacy run time follows wait code
// (RL11) bit 3 picks legacy or new routine
// (RL12) dac iteration starts at field plus one
// (RL13) lock select 5 shows completion, active low
// (RL14) reserved buffer bits ignored, read zero
// (RL15) software clears start before setting again
module sbc_regs #(
    parameter int unsigned LEGACY_CYC0 = `SBC_LEGACY_CYC0,
    parameter int unsigned LEGACY_CYC1 = `SBC_LEGACY_CYC1,
    parameter int unsigned LEGACY_CYC2 = `SBC_LEGACY_CYC2,
    parameter int unsigned LEGACY_CYC3 = `SBC_LEGACY_CYC3
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    output var  logic        irq,
    output var  logic        lock_pin,
    output var  logic [1:0]  prescaler_swing,
    output var  logic [2:0]  lo_tx_swing,
    output var  logic [1:0]  prescaler_current,
    output var  logic [2:0]  lo_tx_current,
    output var  logic [7:0]  loop_bandwidth_scale,
    output var  logic        cal_busy,
    output var  logic [3:0]  cal_dac,
    output var  logic [3:0]  slot_a_dac,
    output var  logic [3:0]  slot_b_dac
);
    sbc_cal_if cal ();

    logic        cal_start, next_cal_start;
    logic        cal_dual, next_cal_dual;
    logic [1:0]  cal_wait, next_cal_wait;
    logic        cal_select, next_cal_select;
    logic [2:0]  calib_dac_start, next_calib_dac_start;
    logic        freq_select, next_freq_select;
    logic [3:0]  lock_select, next_lock_select;
    logic        cal_complete, next_cal_complete;
    logic [1:0]  irq_status, next_irq_status;
    logic [1:0]  irq_mask, next_irq_mask;
    logic        start_pulse, next_start_pulse;
    logic [1:0]  next_prescaler_swing, next_prescaler_current;
    logic [2:0]  next_lo_tx_swing, next_lo_tx_current;
    logic [7:0]  next_loop_bandwidth_scale;
    logic [3:0]  next_slot_a_dac, next_slot_b_dac;
    logic [31:0] next_prdata;
    logic        next_pready, next_pslverr, next_irq, next_lock_pin;
    logic [31:0] rd_val;
    logic        mapped;
    logic        wr_en;
    logic [5:0]  idx;
    logic [1:0]  events;

    // ****************************************
    // address decode and read mux
    // ****************************************
    assign idx = paddr[7:2];

    always_comb begin
        rd_val = 32'h0000_0000;
        mapped = (paddr[1:0] == 2'h0);
        if (idx == `SBC_IDX_SWING) begin
            rd_val[`SBC_F_PRE] = prescaler_swing; // (RL14)
            rd_val[`SBC_F_TX]  = lo_tx_swing;
        end else if (idx == `SBC_IDX_CURRENT) begin
            rd_val[`SBC_F_PRE] = prescaler_current; // (RL14)
            rd_val[`SBC_F_TX]  = lo_tx_current;
        end else if (idx == `SBC_IDX_BW) begin
            rd_val[`SBC_F_BW] = loop_bandwidth_scale;
        end else if (idx == `SBC_IDX_CAL) begin
            rd_val[`SBC_F_CAL_START]  = cal_start;
            rd_val[`SBC_F_CAL_DUAL]   = cal_dual;
            rd_val[`SBC_F_CAL_WAIT]   = cal_wait;
            rd_val[`SBC_F_CAL_SELECT] = cal_select;
            rd_val[`SBC_F_CAL_ITER]   = calib_dac_start;
        end else if (idx == `SBC_IDX_CTRL) begin
            rd_val[`SBC_F_FREQ_SEL] = freq_select;
            rd_val[`SBC_F_LOCK_SEL] = lock_select;
        end else if (idx == `SBC_IDX_RESULT) begin
            rd_val[`SBC_F_RES_A] = slot_a_dac;
            rd_val[`SBC_F_RES_B] = slot_b_dac;
        end else if (idx == `SBC_IDX_STATE) begin
            rd_val[`SBC_F_BUSY]     = cal_busy;
            rd_val[`SBC_F_COMPLETE] = cal_complete;
        end else if (idx == `SBC_IDX_IRQ_STAT) begin
            rd_val[1:0] = irq_status;
        end else if (idx == `SBC_IDX_IRQ_MASK) begin
            rd_val[1:0] = irq_mask;
        end else begin
            mapped = 1'b0;
        end
    end

    // a write lands only at the edge that completes the access phase
    assign wr_en = psel && penable && pready && pwrite && mapped;

    // ****************************************
    // register file, calibration control, events
    // ****************************************
    always_comb begin
        next_prescaler_swing      = prescaler_swing;
        next_lo_tx_swing          = lo_tx_swing;
        next_prescaler_current    = prescaler_current;
        next_lo_tx_current        = lo_tx_current;
        next_loop_bandwidth_scale = loop_bandwidth_scale;
        next_cal_start            = cal_start;
        next_cal_dual             = cal_dual;
        next_cal_wait             = cal_wait;
        next_cal_select           = cal_select;
        next_calib_dac_start      = calib_dac_start;
        next_freq_select          = freq_select;
        next_lock_select          = lock_select;
        next_irq_mask             = irq_mask;
        next_irq_status           = irq_status;
        next_slot_a_dac           = slot_a_dac;
        next_slot_b_dac           = slot_b_dac;
        next_cal_complete         = cal_complete;
        next_start_pulse          = 1'b0;
        events                    = 2'h0;

        if (wr_en && idx == `SBC_IDX_SWING) begin
            next_prescaler_swing = pwdata[`SBC_F_PRE]; // (RL1)
            next_lo_tx_swing     = pwdata[`SBC_F_TX]; // (RL2)
        end

        if (wr_en && idx == `SBC_IDX_CURRENT) begin
            next_prescaler_current = pwdata[`SBC_F_PRE]; // (RL3)
            next_lo_tx_current     = pwdata[`SBC_F_TX]; // (RL4)
        end

        if (wr_en && idx == `SBC_IDX_BW) begin
            next_loop_bandwidth_scale = pwdata[`SBC_F_BW]; // (RL5)
        end

        if (wr_en && idx == `SBC_IDX_CAL) begin
            next_cal_start       = pwdata[`SBC_F_CAL_START];
            next_cal_dual        = pwdata[`SBC_F_CAL_DUAL];
            next_cal_wait        = pwdata[`SBC_F_CAL_WAIT];
            next_cal_select      = pwdata[`SBC_F_CAL_SELECT]; // (RL11)
            next_calib_dac_start = pwdata[`SBC_F_CAL_ITER];

            // only a 0 to 1 change of the stored bit asks for a run
            if (pwdata[`SBC_F_CAL_START] && !cal_start) begin // (RL6)
                if (cal.busy) begin
                    events[`SBC_F_EV_REFUSED] = 1'b1;
                end else begin
                    next_start_pulse  = 1'b1;
                    next_cal_complete = 1'b0;
                end
            end
        end

        if (wr_en && idx == `SBC_IDX_CTRL) begin
            next_freq_select = pwdata[`SBC_F_FREQ_SEL];
            next_lock_select = pwdata[`SBC_F_LOCK_SEL];
        end

        if (wr_en && idx == `SBC_IDX_IRQ_MASK) begin
            next_irq_mask = pwdata[1:0];
        end

        if (cal.done) begin
            next_cal_complete            = 1'b1;
            events[`SBC_F_EV_DONE]       = 1'b1;
            if (cal_dual || !freq_select) begin // (RL7)
                next_slot_a_dac = cal.dac;
            end
            if (cal_dual || freq_select) begin // (RL7)
                next_slot_b_dac = cal.dac;
            end
        end

        // write one to clear; a new event in the same cycle wins
        if (wr_en && idx == `SBC_IDX_IRQ_STAT) begin
            next_irq_status = irq_status & ~pwdata[1:0];
        end

        next_irq_status = next_irq_status | events;
        next_irq        = |(next_irq_status & next_irq_mask);
    end

    // ****************************************
    // bus answer and lock pin
    // ****************************************
    always_comb begin
        // no wait state: pready rises for the first access cycle only
        next_pready  = psel && !penable;
        next_prdata  = (psel && !penable && !pwrite) ? rd_val : 32'h0000_0000;
        next_pslverr = psel && !penable && !mapped;
        // code 1 drives 1; codes other than 1 and 5 feed analog sources kept outside this block, so they drive 0
        if (lock_select == `SBC_LOCK_CAL_DONE) begin
            next_lock_pin = !next_cal_complete; // (RL13)
        end else begin
            next_lock_pin = (lock_select == `SBC_LOCK_HIGH);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescaler_swing      <= `SBC_RST_PRE_SWING; // (RL1)
            lo_tx_swing          <= `SBC_RST_TX_SWING; // (RL2)
            prescaler_current    <= `SBC_RST_PRE_CUR; // (RL3)
            lo_tx_current        <= `SBC_RST_TX_CUR; // (RL4)
            loop_bandwidth_scale <= `SBC_RST_BW; // (RL5)

            cal_start            <= 1'b0; // (RL6)
            cal_dual             <= 1'b0;
            cal_wait             <= `SBC_RST_CAL_WAIT; // (RL10)
            cal_select           <= `SBC_RST_CAL_SELECT; // (RL11)
            calib_dac_start      <= `SBC_RST_CAL_ITER; // (RL12)

            freq_select          <= 1'b0;
            lock_select          <= 4'h0;

            irq_status           <= 2'h0;
            irq_mask             <= 2'h0;

            slot_a_dac           <= `SBC_RST_DAC;
            slot_b_dac           <= `SBC_RST_DAC;
            cal_complete         <= 1'b0;
            start_pulse          <= 1'b0;

            prdata               <= 32'h0000_0000;
            pready               <= 1'b0;
            pslverr              <= 1'b0;
            irq                  <= 1'b0;
            lock_pin             <= 1'b0;
            cal_busy             <= 1'b0;
            cal_dac              <= `SBC_RST_DAC;
        end else begin
            prescaler_swing      <= next_prescaler_swing;
            lo_tx_swing          <= next_lo_tx_swing;
            prescaler_current    <= next_prescaler_current;
            lo_tx_current        <= next_lo_tx_current;
            loop_bandwidth_scale <= next_loop_bandwidth_scale;

            cal_start            <= next_cal_start;
            cal_dual             <= next_cal_dual;
            cal_wait             <= next_cal_wait;
            cal_select           <= next_cal_select;
            calib_dac_start      <= next_calib_dac_start;

            freq_select          <= next_freq_select;
            lock_select          <= next_lock_select;

            irq_status           <= next_irq_status;
            irq_mask             <= next_irq_mask;

            slot_a_dac           <= next_slot_a_dac;
            slot_b_dac           <= next_slot_b_dac;
            cal_complete         <= next_cal_complete;
            start_pulse          <= next_start_pulse;

            prdata               <= next_prdata;
            pready               <= next_pready;
            pslverr              <= next_pslverr;
            irq                  <= next_irq;
            lock_pin             <= next_lock_pin;

            // a copy registered one cycle late mirrors the engine; busy covers the launch cycle too
            cal_busy             <= cal.busy && !cal.done || start_pulse;
            cal_dac              <= cal.dac;
        end
    end

    // ****************************************
    // calibration engine
    // ****************************************
    // settings are sampled by the engine at launch; later writes affect the next run
    assign cal.start     = start_pulse;
    assign cal.legacy    = !cal_select; // (RL11)
    assign cal.wait_code = cal_wait;
    assign cal.dac_start = calib_dac_start;

    sbc_cal_engine #(
        .LEGACY_CYC0 (LEGACY_CYC0),
        .LEGACY_CYC1 (LEGACY_CYC1),
        .LEGACY_CYC2 (LEGACY_CYC2),
        .LEGACY_CYC3 (LEGACY_CYC3)
    ) i_sbc_cal_engine (
        .pclk    (pclk),
        .presetn (presetn),
        .cal     (cal.eng)
    );
endmodule
`default_nettype wire

// [tb/sbc_regs_properties.sv]
// checker for the synthesizer buffer and calibration registers
// assumes: bound to sbc_regs, byte address = 4 * register index
`timescale 1ns/100ps
`default_nettype none
module sbc_regs_properties (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [1:0]  prescaler_swing,
    input wire logic [2:0]  lo_tx_swing,
    input wire logic [7:0]  loop_bandwidth_scale,
    input wire logic        cal_busy,
    input wire logic [3:0]  slot_a_dac,
    input wire logic [3:0]  slot_b_dac
);
    // ****************************************
    // properties
    // ****************************************
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc_w;
    assign acc_w = psel && penable && pready && pwrite;
    sequence s_swing_wr;
        acc_w && paddr == 8'h60;
    endsequence
    answer_next_a: assert property (psel && !penable |=> pready) else $error("no answer");
    ready_single_a: assert property (pready |=> !pready) else $error("pready too long");
    idle_data_a: assert property (!pready |-> prdata == 32'h0) else $error("stale read data");
    err_unmapped_a: assert property (psel && !penable && paddr == 8'h04 |=> pslverr)
        else $error("no error on unmapped");
    swing_write_a: assert property (s_swing_wr |=> lo_tx_swing == $past(pwdata[2:0])
        && prescaler_swing == $past(pwdata[7:6])) else $error("swing not stored");
    bw_write_a: assert property (acc_w && paddr == 8'h68 |=>
        loop_bandwidth_scale == $past(pwdata[7:0])) else $error("scale not stored");
    busy_cause_a: assert property ($rose(cal_busy) |->
        $past(acc_w && paddr == 8'h6C && pwdata[7], 2)) else $error("run without start");
    slot_change_a: assert property ($changed({slot_a_dac, slot_b_dac}) |-> $past(cal_busy))
        else $error("slot changed when idle");
    reserved_zero_a: assert property (pready && !pwrite && paddr[7:3] == 5'h0C
        |-> prdata[31:8] == 24'h0 && prdata[5:3] == 3'h0) else $error("reserved bits set");
endmodule
bind sbc_regs sbc_regs_properties i_sbc_regs_properties (.*);
`default_nettype wire

// [tb/sbc_host.sv]
// host model: apb master, one transfer at a time
// assumes: tasks are called from a process in step with pclk
`timescale 1ns/100ps
`default_nettype none
module sbc_host (
    input  wire logic        pclk,
    output var  logic        psel,
    output var  logic        penable,
    output var  logic        pwrite,
    output var  logic [7:0]  paddr,
    output var  logic [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    // ****************************************
    // bus cycle
    // ****************************************
    initial {psel, penable, pwrite, paddr, pwdata} = 43'h0;
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines must not look like a held request
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule
`default_nettype wire

// [tb/test_synth_buffer_calibration_regs.sv]
// testbench: register values, reserved bits, calibration runs, interrupt
// assumes: legacy run lengths shortened to 170, 180, 330, 520 cycles
`timescale 1ns/100ps
`default_nettype none
module test_synth_buffer_calibration_regs;
    // ****************************************
    // bench
    // ****************************************
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, lock_pin, cal_busy, e;
    logic [7:0]  paddr, loop_bandwidth_scale;
    logic [31:0] pwdata, prdata, r;
    logic [1:0]  prescaler_swing, prescaler_current;
    logic [2:0]  lo_tx_swing, lo_tx_current;
    logic [3:0]  cal_dac, slot_a_dac, slot_b_dac;
    int          error_cnt = 0, checks = 0, cyc = 0;
    int          dv[4] = '{8, 16, 40, 80};
    int          lv[4] = '{170, 180, 330, 520};
    logic [7:0]  ra[5] = '{8'h60, 8'h64, 8'h68, 8'h6C, 8'hD0};
    logic [31:0] rv[5] = '{32'hC1, 32'h45, 32'h86, 32'h0D, 32'h0};
    sbc_regs #(.LEGACY_CYC0(170), .LEGACY_CYC1(180), .LEGACY_CYC2(330), .LEGACY_CYC3(520))
        i_sbc_regs (.*);
    sbc_host i_sbc_host (.*);
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        checks++;
        if (g !== x) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_sbc_host.xfer(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input string n);
        i_sbc_host.xfer(1'b0, a, 32'h0, r, e);
        chk(n, x, r);
    endtask
    task automatic settle;
        repeat (2) @(posedge pclk);
        #1;
    endtask
    // start needs a stored 0 first, so every run clears it
    task automatic run(input logic [7:0] c, input int x);
        int n;
        n = 0;
        wr(8'h6C, 32'h0);
        wr(8'h6C, {24'h0, c | 8'h80});
        settle();
        while (cal_busy === 1'b1) begin
            if (n == 2) chk("dac start", {29'h0, c[2:0]} + 32'h1, {28'h0, cal_dac});
            n++;
            @(posedge pclk);
            #1;
        end
        chk("run length", 32'h1, 32'(n >= x - 1 && n <= x + 1));
    endtask
    task automatic tally_and_finish;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    initial begin
        presetn = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 5; i++) rd(ra[i], rv[i], "reset value");
        wr(8'h60, 32'hFF);
        rd(8'h60, 32'hC7, "swing reserved");
        wr(8'h64, 32'h3A);
        rd(8'h64, 32'h02, "current reserved");
        chk("current pins", 32'h2, {27'h0, prescaler_current, lo_tx_current});
        wr(8'h68, 32'h9A);
        rd(8'h68, 32'h9A, "bandwidth scale");
        i_sbc_host.xfer(1'b0, 8'h04, 32'h0, r, e);
        chk("unmapped error", 32'h1, {31'h0, e});
        wr(8'hC0, 32'h50);
        wr(8'hD0, 32'h1);
        settle();
        chk("lock before run", 32'h1, {31'h0, lock_pin});
        run(8'h0F, 8);
        chk("slot b single", 32'h0, {28'h0, slot_b_dac});
        chk("slot a single", 32'h8, {28'h0, slot_a_dac});
        chk("lock after run", 32'h0, {31'h0, lock_pin});
        chk("irq raised", 32'h1, {31'h0, irq});
        wr(8'hCC, 32'h1);
        settle();
        chk("irq cleared", 32'h0, {31'h0, irq});
        for (int w = 1; w < 4; w++) run(8'h0F | 8'(w << 4), dv[w]);
        run(8'h08, 64);
        wr(8'hD0, 32'h0);
        run(8'h4F, 8);
        chk("slot b dual", 32'h8, {28'h0, slot_b_dac});
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(8'hD0, 32'h1);
        settle();
        chk("irq unmasked", 32'h1, {31'h0, irq});
        for (int w = 0; w < 4; w++) begin
            run(8'h03 | 8'(w << 4), lv[w]);
            chk("legacy dac", 32'h6, {28'h0, slot_a_dac});
        end
        wr(8'h6C, 32'h8F);
        repeat (3) settle();
        chk("no restart", 32'h0, {31'h0, cal_busy});
        tally_and_finish();
    end
endmodule
`default_nettype wire
